// File: include/lrc_defs.vh
// Purpose: Constants for the range configuration loader
// Assumes: Included by bare name from design files
// Notes:   Word of 12 bits, four channels of 3-bit codes
`ifndef LRC_DEFS_VH
`define LRC_DEFS_VH
`define LRC_WORD_W      12
`define LRC_CODE_W      3
`define LRC_CHANNELS    4
`define LRC_CNT_W       4
`define LRC_CNT_LAST    4'hb
`define LRC_CNT_ZERO    4'h0
`define LRC_CFG_RESET   12'hfff
`define LRC_WORD_ZERO   12'h000
`define LRC_CODE_OFF    3'h0
`define LRC_PWRUP_MS    10
`define LRC_CLK_MHZ     25
`define LRC_US_PER_MS   1000
`define LRC_PIN_IDLE    4'h4
`endif

// File: verilog/lrc_sync_edge.v
// Purpose: Two-stage synchroniser with edge detection on the stable stage
// Assumes: One ref_clk domain, synchronous active-high reset
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module lrc_sync_edge #(
  parameter             WIDTH     = 1,
  // Idle level of each pin, so reset never fakes an edge
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // Clock and control
  input  wire             ref_clk,
  input  wire             rst,
  input  wire             clkEn,
  // Asynchronous input
  input  wire [WIDTH-1:0] asyncIn,
  // Synchronised outputs
  output reg  [WIDTH-1:0] syncOut_reg,
  output reg  [WIDTH-1:0] prevOut_reg
);
  reg [WIDTH-1:0] meta_reg;

  // Two flops, then a delayed copy for edge finding
  always @(posedge ref_clk) begin
    if (rst) begin
      meta_reg    <= RESET_VAL;
      syncOut_reg <= RESET_VAL;
      prevOut_reg <= RESET_VAL;
    end else if (clkEn) begin
      meta_reg    <= asyncIn;
      syncOut_reg <= meta_reg;
      prevOut_reg <= syncOut_reg;
    end
  end
endmodule // lrc_sync_edge

// File: verilog/lrc_range_loader.v
// Purpose: Loads the per-channel range configuration from DDR serial words
// Assumes: serial_clock_in far slower than ref_clk (320 ns vs 40 ns period)
// Notes:   Both link clock edges are found by oversampling in ref_clk
`timescale 1ns/1ps
`include "lrc_defs.vh"
module lrc_range_loader #(
  parameter WORD_W      = `LRC_WORD_W,
  parameter CHANNELS    = `LRC_CHANNELS,
  parameter PWRUP_MS    = `LRC_PWRUP_MS,
  // Power-up delay in cycles; shorten in simulation
  parameter PWRUP_CYCLES = PWRUP_MS * `LRC_US_PER_MS * `LRC_CLK_MHZ
) (
  // Clock, reset and enable
  input  wire                   ref_clk,
  input  wire                   rst,
  input  wire                   clkEn,
  // Link pins from the host
  input  wire                   serial_clock_in,
  input  wire                   serial_data_in,
  input  wire                   chipSelectN,
  // Conversion status from the core
  input  wire                   busy,
  input  wire                   convStart,
  // Range outputs towards the converter core
  output reg  [WORD_W-1:0]      rangeCfg_reg,
  output reg  [CHANNELS-1:0]    chanEnable_reg,
  output reg  [WORD_W-1:0]      appliedCfg_reg,
  output reg  [CHANNELS-1:0]    appliedEnable_reg,
  // Window and bus status
  output reg                    windowOpen_reg,
  output reg                    busEnable_reg,
  output reg                    wordLoaded_reg
);
  // Window state machine, one-hot
  localparam [2:0] ST_PWRUP  = 3'h1;
  localparam [2:0] ST_OPEN   = 3'h2;
  localparam [2:0] ST_CLOSED = 3'h4;

  // Synchronised pins: clock, data, chip select, busy
  // All four pins come from the host or the core's busy logic, which
  // run on clocks unrelated to ref_clk, so each passes two flops first.
  // Reset loads the idle levels: clock low, data low, chip select high,
  // busy low. A zero reset on chip select would briefly show a selected
  // bus and raise the bus enable for no reason right after reset.
  // Trade-off: oversampling limits the link to a half period of at least
  // three ref_clk cycles, far below what a dedicated receiver manages.
  wire [3:0] pinSync;
  wire [3:0] pinPrev;
  lrc_sync_edge #(
    .WIDTH       (4),
    .RESET_VAL   (`LRC_PIN_IDLE)
  ) uSync (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .clkEn       (clkEn),
    .asyncIn     ({busy, chipSelectN, serial_data_in, serial_clock_in}),
    .syncOut_reg (pinSync),
    .prevOut_reg (pinPrev)
  );

  wire sclkEdge = pinSync[0] ^ pinPrev[0];
  wire sdata    = pinPrev[1]; // Data as it stood just before the edge
  wire csLow    = ~pinSync[2];
  wire busyFall = pinPrev[3] & ~pinSync[3];

  // Enable bit per channel: any nonzero code
  function [CHANNELS-1:0] enables;
    input [WORD_W-1:0] cfg;
    integer k;
    begin
      enables = {CHANNELS{1'b0}};
      for (k = 0; k < CHANNELS; k = k + 1) begin
        enables[k] = (cfg[k*`LRC_CODE_W +: `LRC_CODE_W] != `LRC_CODE_OFF);
      end
    end
  endfunction

  reg [2:0]          state_reg;
  reg [2:0]          state_next;
  reg [31:0]         pwrCnt_reg;
  reg [`LRC_CNT_W-1:0] edgeCnt_reg;
  reg [WORD_W-2:0]   shift_reg;
  wire [WORD_W-1:0]  rxWord = {shift_reg, sdata}; // MSB arrives first

  // Window sequencing
  // The first window waits out the power-up delay; later windows open on
  // the synchronised fall of busy. A conversion start closes the window,
  // so link edges during a conversion are simply not counted.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_PWRUP: begin
        if (pwrCnt_reg == PWRUP_CYCLES - 1) begin
          state_next = ST_OPEN; // opens after reset delay
        end
      end
      ST_OPEN: begin
        if (convStart) begin
          state_next = ST_CLOSED;
        end
      end
      ST_CLOSED: begin
        if (busyFall) begin
          state_next = ST_OPEN; // opens at end of conversion
        end
      end
      default: begin
        state_next = ST_PWRUP;
      end
    endcase
  end

  // A fresh window wipes partial progress so no group spans windows
  wire windowStart = (state_next == ST_OPEN) && (state_reg != ST_OPEN);
  wire takeEdge    = (state_reg == ST_OPEN) && csLow && sclkEdge;
  wire groupDone   = takeEdge && (edgeCnt_reg == `LRC_CNT_LAST);
  wire doLoad      = groupDone && (rxWord != `LRC_WORD_ZERO);

  // Power-up delay counter; stops once the first window opens
  always @(posedge ref_clk) begin
    if (rst) begin
      pwrCnt_reg <= 32'h0;
    end else if (clkEn) begin
      if (state_reg == ST_PWRUP) begin
        pwrCnt_reg <= pwrCnt_reg + 32'h1;
      end
    end
  end

  // Window state and its registered status flag
  always @(posedge ref_clk) begin
    if (rst) begin
      state_reg      <= ST_PWRUP;
      windowOpen_reg <= 1'b0;
    end else if (clkEn) begin
      state_reg      <= state_next;
      windowOpen_reg <= (state_next == ST_OPEN);
    end
  end

  // Bus enable; no tristate here, the core uses this flag
  always @(posedge ref_clk) begin
    if (rst) begin
      busEnable_reg <= 1'b0;
    end else if (clkEn) begin
      busEnable_reg <= csLow;
    end
  end

  // Edge counter and shifter
  // Trailing partial groups stay in the counter until the next window
  // opens; that and reset are the only places they are thrown away.
  always @(posedge ref_clk) begin
    if (rst) begin
      edgeCnt_reg <= `LRC_CNT_ZERO;
      shift_reg   <= {(WORD_W-1){1'b0}};
    end else if (clkEn) begin
      if (windowStart) begin
        edgeCnt_reg <= `LRC_CNT_ZERO;
        shift_reg   <= {(WORD_W-1){1'b0}};
      end else if (takeEdge) begin
        edgeCnt_reg <= groupDone ? `LRC_CNT_ZERO : edgeCnt_reg + 4'h1;
        shift_reg   <= rxWord[WORD_W-2:0];
      end
    end
  end

  // Immediate load; channel disable takes effect at once
  always @(posedge ref_clk) begin
    if (rst) begin
      rangeCfg_reg   <= `LRC_CFG_RESET;
      chanEnable_reg <= {CHANNELS{1'b1}};
      wordLoaded_reg <= 1'b0;
    end else if (clkEn) begin
      wordLoaded_reg <= doLoad;
      if (doLoad) begin
        rangeCfg_reg   <= rxWord;
        chanEnable_reg <= enables(rxWord);
      end
    end
  end

  // Settings latched at conversion start, no extra settle delay
  // A word finishing in the very cycle of the start still counts.
  always @(posedge ref_clk) begin
    if (rst) begin
      appliedCfg_reg    <= `LRC_CFG_RESET;
      appliedEnable_reg <= {CHANNELS{1'b1}};
    end else if (clkEn) begin
      if (convStart) begin
        appliedCfg_reg    <= doLoad ? rxWord : rangeCfg_reg;
        appliedEnable_reg <= doLoad ? enables(rxWord) : chanEnable_reg;
      end
    end
  end
endmodule // lrc_range_loader

// File: test/lrc_range_loader_assertions.sv
// Purpose: Port-level checks of the range loader
// Assumes: Default widths, clkEn held high
// Notes:   Bound into every loader instance
`timescale 1ns/1ps
module lrc_range_loader_assertions(
  input wire logic        ref_clk, rst, clkEn, serial_clock_in, serial_data_in,
  input wire logic        chipSelectN, busy, convStart,
  input wire logic        windowOpen_reg, busEnable_reg, wordLoaded_reg,
  input wire logic [11:0] rangeCfg_reg, appliedCfg_reg,
  input wire logic [3:0]  chanEnable_reg, appliedEnable_reg);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Chip select settled past the synchroniser
  sequence csHeld(v); (chipSelectN == v) [*6]; endsequence
  a_cfg_cause: assert property ($changed(rangeCfg_reg) |-> wordLoaded_reg)
    else $error("config changed without load");
  a_load_nonzero: assert property (wordLoaded_reg |-> rangeCfg_reg != 12'h000)
    else $error("zero word loaded");
  a_enable_map: assert property (chanEnable_reg == {|rangeCfg_reg[11:9],
    |rangeCfg_reg[8:6], |rangeCfg_reg[5:3], |rangeCfg_reg[2:0]}) else $error("enable map");
  a_load_window: assert property (wordLoaded_reg |-> $past(windowOpen_reg))
    else $error("load outside window");
  a_load_pulse: assert property (wordLoaded_reg |=> !wordLoaded_reg)
    else $error("load pulse too long");
  a_bus_on: assert property (csHeld(1'b0) |-> busEnable_reg)
    else $error("bus not enabled");
  a_bus_off: assert property (csHeld(1'b1) |-> !busEnable_reg)
    else $error("bus not released");
  a_conv_apply: assert property (convStart |=> appliedCfg_reg == rangeCfg_reg
    && appliedEnable_reg == chanEnable_reg) else $error("applied config wrong");
  a_applied_hold: assert property (!convStart |=> $stable(appliedCfg_reg))
    else $error("applied config moved");
  a_window_open: assert property ($fell(busy) |-> ##[3:6] windowOpen_reg)
    else $error("window did not open");
endmodule // lrc_range_loader_assertions
bind lrc_range_loader lrc_range_loader_assertions i_lrc_range_loader_assertions(.*);

// File: test/lrc_host_model.sv
// Purpose: Host side of the link, DDR words MSB first
// Assumes: Half period 160 ns, data set 80 ns before edge
// Notes:   Edge count kept even so the clock idles low
`timescale 1ns/1ps
module lrc_host_model(
  output logic sclk = 1'b0,
  output logic sdat = 1'b0,
  output logic csN  = 1'b1);
  // Caller puts the word at the top of w; only the first n bits are sent
  task automatic send(input [31:0] w, input int n);
    csN = 1'b0;
    #160;
    for (int i = 0; i < n; i++) begin
      sdat = w[31-i];
      #80 sclk = ~sclk;
      #80;
    end
    #160 csN = 1'b1;
    sdat = ~sdat; // Released line does not keep its value
  endtask
endmodule // lrc_host_model

// File: test/lrc_range_loader_test.sv
// Purpose: Self-checking bench for the range loader
// Assumes: Power-up delay shortened to 20 cycles
// Notes:   Host model drives the link pins
`timescale 1ns/1ps
module lrc_range_loader_test;
  logic ref_clk = 0, rst = 1, busy = 0, convStart = 0;
  wire sclk, sdat, csN, win, busEn, ld;
  wire [11:0] cfg, apCfg;
  wire [3:0] en, apEn;
  int n_mismatch = 0, total_checks = 0, n_loads = 0;
  always #20 ref_clk = ~ref_clk;
  // Count load pulses as they stand just before each edge
  always @(posedge ref_clk) if (ld === 1'b1) n_loads++;
  lrc_host_model i_lrc_host_model(.sclk(sclk), .sdat(sdat), .csN(csN));
  lrc_range_loader #(.PWRUP_CYCLES(20)) i_lrc_range_loader(.ref_clk(ref_clk), .rst(rst),
    .clkEn(1'b1), .serial_clock_in(sclk), .serial_data_in(sdat), .chipSelectN(csN),
    .busy(busy), .convStart(convStart), .rangeCfg_reg(cfg), .chanEnable_reg(en),
    .appliedCfg_reg(apCfg), .appliedEnable_reg(apEn), .windowOpen_reg(win),
    .busEnable_reg(busEn), .wordLoaded_reg(ld));
  task chk(input [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One conversion; the link is driven while the window is shut
  task conv(input [31:0] w, input int n);
    @(posedge ref_clk); #1 convStart = 1; busy = 1;
    @(posedge ref_clk); #1 convStart = 0;
    i_lrc_host_model.send(w, n);
    busy = 0;
    repeat (8) @(posedge ref_clk); #1;
  endtask
  task t_reset;
    chk({apCfg, en}, 16'hfff_f);
    repeat (24) @(posedge ref_clk); #1;
    chk(win, 1'b1);
    chk(busEn, 1'b0);
  endtask
  task t_load;
    fork
      i_lrc_host_model.send({12'h1c5, 20'h0}, 12);
      begin repeat (8) @(posedge ref_clk); #1 chk(busEn, 1'b1); end
    join
    chk({cfg, en}, 16'h1c5_5);
    chk(n_loads, 1);
    i_lrc_host_model.send({12'habc, 20'h0}, 8);
    chk(cfg, 12'h1c5);
    conv({12'h0f0, 20'h0}, 12);
    chk({cfg, apCfg, apEn}, 28'h1c5_1c5_5);
    i_lrc_host_model.send(32'h0, 12);
    chk(cfg, 12'h1c5);
    chk(n_loads, 1);
  endtask
  task t_groups;
    i_lrc_host_model.send({12'h7ff, 12'h000, 8'hff}, 28);
    chk(cfg, 12'h7ff);
    chk(n_loads, 2);
    conv(32'h0, 0);
    i_lrc_host_model.send({8'hff, 24'h0}, 8);
    chk({cfg, win}, 13'h0fff);
    chk(n_loads, 2);
  endtask
  // Reset in mid-run returns every setting to all ones
  task t_rerst;
    @(posedge ref_clk); #1 rst = 1;
    repeat (3) @(posedge ref_clk); #1 rst = 0;
    chk({cfg, apCfg, en, apEn}, 32'hfff_fff_f_f);
    chk(win, 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk); #1 rst = 0;
    t_reset;
    t_load;
    t_groups;
    t_rerst;
    stop_test;
  end
  // Hang guard well beyond the expected run
  initial begin
    #200000 n_mismatch++;
    stop_test;
  end
endmodule // lrc_range_loader_test
